// file: hdl/ddl_load_ctrl.sv
// Top of the DAC double-buffer load control: registers, load events, channel latches
//
// Strobed register access and the register offsets were decided locally.
module ddl_load_ctrl
#(
  parameter int NUM_CHAN = ddl_pkg::DDL_NUM_CHAN
)
(
  // System
  input  wire logic                                   clock,
  input  wire logic                                   nrst,
  // Register port
  input  ddl_pkg::ddl_bus_req_type                    bus_req,
  output logic [ddl_pkg::DDL_DATA_W-1:0]              rdata,
  // External load pin
  input  wire logic                                   ext_load_pin,
  // Converter side
  output ddl_pkg::ddl_chan_out_type [NUM_CHAN-1:0]    chan_out,
  output logic                                        ref_source_sel,
  output logic                                        ref_level_sel
);
  import ddl_pkg::*;

  // Channel index is three bits and field slots are eight wide
  if (NUM_CHAN < 1 || NUM_CHAN > DDL_NUM_CHAN)
  begin : g_bad_chan
    $error("NUM_CHAN must lie between 1 and 8");
  end

  // Control and status registers
  logic [NUM_CHAN-1:0]   sync_load_sel_ff;
  logic [NUM_CHAN-1:0]   out_gain_sel_ff;
  logic [NUM_CHAN-1:0]   chan_power_en_ff;
  logic                  ref_source_sel_ff;
  logic                  ref_level_sel_ff;
  logic                  int_load_strobe_ff;
  logic [DDL_DATA_W-1:0] load_cnt_ff;
  logic [DDL_DATA_W-1:0] rdata_ff;

  logic [NUM_CHAN-1:0]   nxt_sync_load_sel;
  logic [NUM_CHAN-1:0]   nxt_out_gain_sel;
  logic [NUM_CHAN-1:0]   nxt_chan_power_en;
  logic                  nxt_ref_source_sel;
  logic                  nxt_ref_level_sel;
  logic                  nxt_int_load_strobe;
  logic [DDL_DATA_W-1:0] nxt_load_cnt;
  logic [DDL_DATA_W-1:0] nxt_rdata;

  // Double buffer per channel
  logic [DDL_CODE_W-1:0] in_reg_ff   [NUM_CHAN];
  logic [DDL_CODE_W-1:0] latch_ff    [NUM_CHAN];
  logic [DDL_CODE_W-1:0] nxt_in_reg  [NUM_CHAN];
  logic [DDL_CODE_W-1:0] nxt_latch   [NUM_CHAN];
  logic [NUM_CHAN-1:0]   pending;

  // Load pin after synchronisation
  logic                  pin_level;
  logic                  ext_rise;
  logic                  load_event;

  // Address decode
  wire  [DDL_ADDR_W-1:0] addr      = bus_req.addr;
  wire  [DDL_DATA_W-1:0] wdata     = bus_req.wdata;
  wire  [2:0]            chan_idx  = addr[2:0];
  wire                   chan_hit  = (addr[3] == DDL_OFF_DATA0[3])
                                     && ({1'b0, chan_idx} < 4'(NUM_CHAN));
  wire                   wr_data   = bus_req.wr && chan_hit;
  wire                   wr_cfg    = bus_req.wr && (addr == DDL_OFF_CFG);
  wire                   wr_load   = bus_req.wr && (addr == DDL_OFF_LOAD);
  wire                   wr_pwr    = bus_req.wr && (addr == DDL_OFF_PWR);
  wire                   wr_ref    = bus_req.wr && (addr == DDL_OFF_REF);
  wire                   wr_magic  = wr_load && (wdata == DDL_LOAD_MAGIC);

  // Load pin crosses into the clock domain before any use
  ddl_edge_sync u_pin_sync
  (
    .clock (clock),
    .nrst  (nrst),
    .din   (ext_load_pin),
    .level (pin_level),
    .rise  (ext_rise)
  );

  // Any other value written to the load register is ignored
  assign nxt_int_load_strobe = wr_magic;
  assign load_event          = int_load_strobe_ff | ext_rise;

  assign nxt_sync_load_sel  = wr_cfg ? wdata[DDL_CFG_SYNC_LSB +: NUM_CHAN]
                                     : sync_load_sel_ff;
  assign nxt_out_gain_sel   = wr_cfg ? wdata[DDL_CFG_GAIN_LSB +: NUM_CHAN]
                                     : out_gain_sel_ff;
  assign nxt_chan_power_en  = wr_pwr ? wdata[DDL_PWR_EN_LSB +: NUM_CHAN]
                                     : chan_power_en_ff;
  assign nxt_ref_source_sel = wr_ref ? wdata[DDL_REF_SRC_BIT] : ref_source_sel_ff;
  assign nxt_ref_level_sel  = wr_ref ? wdata[DDL_REF_LVL_BIT] : ref_level_sel_ff;
  // Counter wraps; it only helps software see that loads arrived
  assign nxt_load_cnt       = load_event ? load_cnt_ff + 16'h0001 : load_cnt_ff;

  // One double buffer and output stage per channel
  for (genvar i = 0; i < NUM_CHAN; i++)
  begin : g_chan
    wire wr_this = wr_data && (chan_idx == 3'(i));
    wire direct  = !sync_load_sel_ff[i] && wr_this;
    wire synced  = sync_load_sel_ff[i] && load_event;

    assign nxt_in_reg[i] = wr_this ? wdata[DDL_CODE_W-1:0] : in_reg_ff[i];
    // A load landing with a write takes the value held before that write
    assign nxt_latch[i]  = direct ? wdata[DDL_CODE_W-1:0]
                         : synced ? in_reg_ff[i]
                         : latch_ff[i];
    assign pending[i]    = (in_reg_ff[i] != latch_ff[i]);

    always_ff @(posedge clock or negedge nrst)
    begin
      if (!nrst)
      begin
        in_reg_ff[i] <= DDL_CODE_RST;
        latch_ff[i]  <= DDL_CODE_RST;
      end
      else
      begin
        in_reg_ff[i] <= nxt_in_reg[i];
        latch_ff[i]  <= nxt_latch[i];
      end
    end

    // Output follows the latch only, and only while the channel is up
    ddl_chan_out u_out
    (
      .clock         (clock),
      .nrst          (nrst),
      .latch_code    (latch_ff[i]),
      .out_gain_sel  (out_gain_sel_ff[i]),
      .chan_power_en (chan_power_en_ff[i]),
      .chan_out      (chan_out[i])
    );
  end

  // Read selection; unmapped and unused locations read as zero
  wire [DDL_DATA_W-1:0] rd_chan = chan_hit
                                  ? 16'(latch_ff[chan_idx]) : DDL_WORD_RST;
  wire [DDL_DATA_W-1:0] rd_cfg  = {8'(out_gain_sel_ff), 8'(sync_load_sel_ff)};
  wire [DDL_DATA_W-1:0] rd_pwr  = 16'(chan_power_en_ff);
  wire [DDL_DATA_W-1:0] rd_ref  = {14'h0000, ref_level_sel_ff, ref_source_sel_ff};
  wire [DDL_DATA_W-1:0] rd_stat = {7'h00, pin_level, 8'(pending)};
  wire [DDL_DATA_W-1:0] rd_sel  = chan_hit               ? rd_chan
                                : (addr == DDL_OFF_CFG)  ? rd_cfg
                                : (addr == DDL_OFF_PWR)  ? rd_pwr
                                : (addr == DDL_OFF_REF)  ? rd_ref
                                : (addr == DDL_OFF_STAT) ? rd_stat
                                : (addr == DDL_OFF_LCNT) ? load_cnt_ff
                                : DDL_WORD_RST;
  // Read data stands only in the cycle after the strobe
  assign nxt_rdata = bus_req.rd ? rd_sel : DDL_WORD_RST;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_load_sel_ff   <= DDL_SEL_RST[NUM_CHAN-1:0];
      out_gain_sel_ff    <= DDL_SEL_RST[NUM_CHAN-1:0];
      chan_power_en_ff   <= DDL_SEL_RST[NUM_CHAN-1:0];
      ref_source_sel_ff  <= DDL_REF_RST;
      ref_level_sel_ff   <= DDL_REF_RST;
      int_load_strobe_ff <= 1'b0;
      load_cnt_ff        <= DDL_WORD_RST;
      rdata_ff           <= DDL_WORD_RST;
    end
    else
    begin
      sync_load_sel_ff   <= nxt_sync_load_sel;
      out_gain_sel_ff    <= nxt_out_gain_sel;
      chan_power_en_ff   <= nxt_chan_power_en;
      ref_source_sel_ff  <= nxt_ref_source_sel;
      ref_level_sel_ff   <= nxt_ref_level_sel;
      int_load_strobe_ff <= nxt_int_load_strobe;
      load_cnt_ff        <= nxt_load_cnt;
      rdata_ff           <= nxt_rdata;
    end
  end

  assign rdata          = rdata_ff;
  assign ref_source_sel = ref_source_sel_ff;
  assign ref_level_sel  = ref_level_sel_ff;

endmodule

// file: include/ddl_pkg.sv
// Constants and carrier types shared by the DAC double-buffer load control block
package ddl_pkg;

  // Sizes
  localparam int DDL_NUM_CHAN = 8;
  localparam int DDL_CODE_W   = 12;
  localparam int DDL_ADDR_W   = 4;
  localparam int DDL_DATA_W   = 16;

  // Register offsets (word index on the register port)
  localparam logic [DDL_ADDR_W-1:0] DDL_OFF_DATA0 = 4'h0;
  localparam logic [DDL_ADDR_W-1:0] DDL_OFF_CFG   = 4'h8;
  localparam logic [DDL_ADDR_W-1:0] DDL_OFF_LOAD  = 4'h9;
  localparam logic [DDL_ADDR_W-1:0] DDL_OFF_PWR   = 4'hA;
  localparam logic [DDL_ADDR_W-1:0] DDL_OFF_REF   = 4'hB;
  localparam logic [DDL_ADDR_W-1:0] DDL_OFF_STAT  = 4'hC;
  localparam logic [DDL_ADDR_W-1:0] DDL_OFF_LCNT  = 4'hD;

  // Field positions
  localparam int DDL_CFG_SYNC_LSB = 0;
  localparam int DDL_CFG_GAIN_LSB = 8;
  localparam int DDL_PWR_EN_LSB   = 0;
  localparam int DDL_REF_SRC_BIT  = 0;
  localparam int DDL_REF_LVL_BIT  = 1;
  localparam int DDL_STAT_PEND_LSB = 0;
  localparam int DDL_STAT_PIN_BIT  = 8;

  // Magic value that raises the internal load strobe
  localparam logic [DDL_DATA_W-1:0] DDL_LOAD_MAGIC = 16'hBB00;

  // Reset values
  localparam logic [DDL_CODE_W-1:0] DDL_CODE_RST = 12'h000;
  localparam logic [DDL_NUM_CHAN-1:0] DDL_SEL_RST = 8'h00;
  localparam logic [DDL_DATA_W-1:0] DDL_WORD_RST = 16'h0000;
  localparam logic DDL_REF_RST = 1'b0;

  // One register port request
  typedef struct packed {
    logic [DDL_ADDR_W-1:0] addr;
    logic [DDL_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } ddl_bus_req_type;

  // One channel's drive toward the analog converter
  typedef struct packed {
    logic [DDL_CODE_W-1:0] code;
    logic                  gain_x2;
    logic                  active;
  } ddl_chan_out_type;

endpackage

// file: hdl/ddl_edge_sync.sv
// Two-stage synchroniser with rising-edge pulse for the external load pin
module ddl_edge_sync
(
  // System
  input  wire logic clock,
  input  wire logic nrst,
  // Asynchronous input
  input  wire logic din,
  // Synchronised results
  output logic      level,
  output logic      rise
);
  import ddl_pkg::*;

  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic rise_ff;
  logic nxt_rise;

  // Edge taken from second and third stage only; the first stage is never read here
  assign nxt_rise = sync_ff & ~last_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
      rise_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
      rise_ff <= nxt_rise;
    end
  end

  assign level = sync_ff;
  assign rise  = rise_ff;

endmodule

// file: hdl/ddl_chan_out.sv
// Output stage of one channel: follows the latch only while powered up
module ddl_chan_out
(
  // System
  input  wire logic                      clock,
  input  wire logic                      nrst,
  // Channel state
  input  wire logic [ddl_pkg::DDL_CODE_W-1:0] latch_code,
  input  wire logic                      out_gain_sel,
  input  wire logic                      chan_power_en,
  // Toward the converter
  output ddl_pkg::ddl_chan_out_type      chan_out
);
  import ddl_pkg::*;

  ddl_chan_out_type out_ff;
  ddl_chan_out_type nxt_out;

  // Powered down: buffer grounded, code and gain frozen until power returns
  assign nxt_out.code    = chan_power_en ? latch_code : out_ff.code;
  assign nxt_out.gain_x2 = chan_power_en ? out_gain_sel : out_ff.gain_x2;
  assign nxt_out.active  = chan_power_en;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      out_ff <= '{code: DDL_CODE_RST, gain_x2: 1'b0, active: 1'b0};
    end
    else
    begin
      out_ff <= nxt_out;
    end
  end

  assign chan_out = out_ff;

endmodule

// file: verification/ddl_load_ctrl_props.sv
// Port checks for the DAC double-buffer load control
module ddl_load_ctrl_props
#(
  parameter int NUM_CHAN = ddl_pkg::DDL_NUM_CHAN
)
(
  // System
  input  wire logic                                clock,
  input  wire logic                                nrst,
  // Register port
  input  ddl_pkg::ddl_bus_req_type                 bus_req,
  input  wire logic [ddl_pkg::DDL_DATA_W-1:0]      rdata,
  // Pin and converter side
  input  wire logic                                ext_load_pin,
  input  ddl_pkg::ddl_chan_out_type [NUM_CHAN-1:0] chan_out,
  input  wire logic                                ref_source_sel,
  input  wire logic                                ref_level_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  import ddl_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire ref_wr = bus_req.wr && bus_req.addr == DDL_OFF_REF;
  wire pwr_wr = bus_req.wr && bus_req.addr == DDL_OFF_PWR;
  wire cfg_wr = bus_req.wr && bus_req.addr == DDL_OFF_CFG;
  AST_RD_IDLE: assert property (!$past(bus_req.rd) |-> rdata == 16'h0000)
    else $error("read data outside answer cycle");
  AST_RD_ZERO: assert property (bus_req.rd && bus_req.addr inside {4'h9, 4'hE, 4'hF}
    |=> rdata == 16'h0000) else $error("load or unmapped read not zero");
  AST_RD_DATA_HI: assert property (bus_req.rd && bus_req.addr < 4'h8 |=> rdata[15:12] == 4'h0)
    else $error("code readback upper bits set");
  AST_REF_WRITE: assert property (ref_wr |=> ref_source_sel == $past(bus_req.wdata[0])
    && ref_level_sel == $past(bus_req.wdata[1])) else $error("reference bits not written");
  AST_REF_HOLD: assert property (!$past(ref_wr) |-> $stable({ref_source_sel, ref_level_sel}))
    else $error("reference bits moved");
  for (genvar i = 0; i < NUM_CHAN; i++)
  begin : g_chan
    AST_ACT_RISE: assert property ($rose(chan_out[i].active)
      |-> $past(pwr_wr, 2) && $past(bus_req.wdata[i], 2)) else $error("power up without enable");
    AST_ACT_FALL: assert property ($fell(chan_out[i].active)
      |-> $past(pwr_wr, 2) && !$past(bus_req.wdata[i], 2)) else $error("power down unasked");
    AST_DOWN_FROZEN: assert property (!chan_out[i].active ##1 !chan_out[i].active
      |-> $stable(chan_out[i].code) && $stable(chan_out[i].gain_x2)) else $error("output moved");
    AST_GAIN_CAUSE: assert property ($changed(chan_out[i].gain_x2) && $past(chan_out[i].active)
      && $past(chan_out[i].active, 2) |-> $past(cfg_wr, 2)) else $error("gain moved unasked");
  end
endmodule

bind ddl_load_ctrl ddl_load_ctrl_props #(.NUM_CHAN(NUM_CHAN)) u_props
(
  .clock(clock), .nrst(nrst), .bus_req(bus_req), .rdata(rdata), .ext_load_pin(ext_load_pin),
  .chan_out(chan_out), .ref_source_sel(ref_source_sel), .ref_level_sel(ref_level_sel)
);

// file: verification/ddl_host_model.sv
// Host model: register port master and external load pin driver
module ddl_host_model
(
  // System
  input  wire logic                           clock,
  // Register port
  output ddl_pkg::ddl_bus_req_type            bus_req,
  input  wire logic [ddl_pkg::DDL_DATA_W-1:0] rdata,
  // Load pin
  output logic                                ext_load_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  import ddl_pkg::*;
  initial
  begin
    bus_req = '0;
    ext_load_pin = 1'b0;
  end
  // Released bus shows inverted address and data so stale values cannot pass
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req <= '{addr: ~a, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata;
  endtask
  // Pin level held six clocks, so a high and a low call make one 48 ns period
  task automatic pin_drive(input logic v);
    @(posedge clock);
    ext_load_pin <= v;
    repeat (5) @(posedge clock);
  endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench for the DAC double-buffer load control
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ddl_pkg::*;
  logic clock, nrst, ext_load_pin, ref_source_sel, ref_level_sel;
  ddl_bus_req_type bus_req;
  logic [15:0] rdata, lcnt, st;
  ddl_chan_out_type [7:0] chan_out;
  logic [11:0] in_reg [8], latch [8], shown [8];
  logic [7:0] sync_m, gain_m, pwr_m, shown_g;
  logic [1:0] ref_v;
  int num_errors, total_checks, seed;
  ddl_load_ctrl #(.NUM_CHAN(8)) u_dut (.clock(clock), .nrst(nrst), .bus_req(bus_req),
    .rdata(rdata), .ext_load_pin(ext_load_pin), .chan_out(chan_out),
    .ref_source_sel(ref_source_sel), .ref_level_sel(ref_level_sel));
  ddl_host_model u_host (.clock(clock), .bus_req(bus_req), .rdata(rdata),
    .ext_load_pin(ext_load_pin));
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic void do_load();
    for (int i = 0; i < 8; i++)
      if (sync_m[i])
        latch[i] = in_reg[i];
    lcnt++;
  endfunction
  function automatic logic [15:0] exp_rd(input logic [3:0] a);
    logic [7:0] p;
    for (int i = 0; i < 8; i++)
      p[i] = in_reg[i] != latch[i];
    if (a < 4'h8)
      return {4'h0, latch[a[2:0]]};
    case (a)
      DDL_OFF_CFG: return {gain_m, sync_m};
      DDL_OFF_PWR: return {8'h00, pwr_m};
      DDL_OFF_REF: return {14'h0000, ref_v};
      DDL_OFF_STAT: return {8'h00, p};
      DDL_OFF_LCNT: return lcnt;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic bw(input logic [3:0] a, input logic [15:0] d);
    u_host.reg_wr(a, d);
    if (a < 4'h8)
    begin
      in_reg[a[2:0]] = d[11:0];
      if (!sync_m[a[2:0]])
        latch[a[2:0]] = d[11:0];
    end
    else if (a == DDL_OFF_CFG)
      {gain_m, sync_m} = d;
    else if (a == DDL_OFF_LOAD && d == DDL_LOAD_MAGIC)
      do_load();
    else if (a == DDL_OFF_PWR)
      pwr_m = d[7:0];
    else if (a == DDL_OFF_REF)
      ref_v = d[1:0];
  endtask
  task automatic chk_all();
    logic [15:0] v;
    for (int a = 0; a < 16; a++)
    begin
      u_host.reg_rd(a[3:0], v);
      chk("register", exp_rd(a[3:0]), v);
    end
    repeat (6) @(posedge clock);
    #1;
    for (int i = 0; i < 8; i++)
    begin
      if (pwr_m[i])
        {shown[i], shown_g[i]} = {latch[i], gain_m[i]};
      chk("chan_out", {2'h0, shown[i], shown_g[i], pwr_m[i]}, 16'(chan_out[i]));
    end
    chk("ref", {14'h0000, ref_v}, {14'h0000, ref_level_sel, ref_source_sel});
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {seed, num_errors, total_checks, nrst, lcnt} = {32'd10, 32'd0, 32'd0, 1'b0, 16'h0000};
    {sync_m, gain_m, pwr_m, shown_g, ref_v} = '0;
    in_reg = '{default: '0};
    latch = '{default: '0};
    shown = '{default: '0};
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    chk_all();
    bw(DDL_OFF_REF, 16'($random(seed)));
    bw(DDL_OFF_PWR, 16'h00FF);
    bw(DDL_OFF_CFG, {8'($random(seed)), 8'h00});
    for (int i = 0; i < 8; i++)
      bw(i[3:0], 16'($random(seed)));
    bw(DDL_OFF_LCNT, 16'($random(seed)));
    chk_all();
    for (int k = 0; k < 2; k++)
    begin
      bw(DDL_OFF_CFG, {gain_m, 8'($random(seed))});
      for (int i = 0; i < 8; i++)
        bw(i[3:0], 16'($random(seed)));
      bw(DDL_OFF_LOAD, 16'hBB01);
      chk_all();
      if (k == 0)
        bw(DDL_OFF_LOAD, DDL_LOAD_MAGIC);
      else
      begin
        u_host.pin_drive(1'b1);
        do_load();
        u_host.reg_rd(DDL_OFF_STAT, st);
        chk("status", exp_rd(DDL_OFF_STAT) | (16'h0001 << DDL_STAT_PIN_BIT), st);
        u_host.pin_drive(1'b0);
      end
      repeat (8) @(posedge clock);
      chk_all();
    end
    bw(DDL_OFF_PWR, 16'h005A);
    bw(DDL_OFF_CFG, {~gain_m, 8'h00});
    for (int i = 0; i < 8; i++)
      bw(i[3:0], 16'($random(seed)));
    chk_all();
    bw(DDL_OFF_PWR, 16'h00FF);
    chk_all();
    test_done();
  end
endmodule
